// ==== core/dtcc_consts.vh ====
// Purpose: Constants of the dual timer configuration and control block
// Assumes: Included by bare name from the core design files
// Notes: Byte offsets, field positions, reset values and mode codes
`ifndef DTCC_CONSTS_VH
`define DTCC_CONSTS_VH

// Register byte offsets
`define DTCC_OFS_CFG_ALL 12'h000
`define DTCC_OFS_CFG_SET 12'h004
`define DTCC_OFS_CFG_CLR 12'h008
`define DTCC_OFS_PRESC 12'h010

// Configuration register fields
`define DTCC_B_HOVF 31
`define DTCC_B_HEXT 30
`define DTCC_B_HIGH_RUN_BIT 29
`define DTCC_B_HIGH_STATE_BIT 28
`define DTCC_B_HMD_HI 27
`define DTCC_B_HMD_LO 24
`define DTCC_B_HOVF_EN 23
`define DTCC_B_HEXT_EN 22
`define DTCC_B_DBG 21
`define DTCC_B_HMSTR 20
`define DTCC_B_MRUN 19
`define DTCC_B_HCLK_HI 17
`define DTCC_B_HCLK_LO 16
`define DTCC_B_LOVF 15
`define DTCC_B_LEXT 14
`define DTCC_B_LOW_RUN_BIT 13
`define DTCC_B_LOW_STATE_BIT 12
`define DTCC_B_LMD_HI 10
`define DTCC_B_LMD_LO 8
`define DTCC_B_LOVF_EN 7
`define DTCC_B_LEXT_EN 6
`define DTCC_B_SPLIT 5
`define DTCC_B_LMSTR 4
`define DTCC_B_LOW_CLOCK_SELECT_HI 1
`define DTCC_B_LOW_CLOCK_SELECT_LO 0

`define DTCC_CFG_RESET 32'h0000_0000
`define DTCC_CFG_WMASK 32'hfffb_f7f3

// Prescaler register fields
`define DTCC_B_PRL_HI 7
`define DTCC_B_PRL_LO 0
`define DTCC_B_PCT_HI 23
`define DTCC_B_PCT_LO 16
`define DTCC_PRESC_RESET 8'h00
`define DTCC_PRESC_TOP 8'hff

// Timer modes
`define DTCC_MD_RELOAD 4'h0
`define DTCC_MD_UPDOWN 4'h1
`define DTCC_MD_CAP_FALL 4'h2
`define DTCC_MD_CAP_RISE 4'h3
`define DTCC_MD_CAP_LOW 4'h4
`define DTCC_MD_CAP_HIGH 4'h5
`define DTCC_MD_CAP_DUTY 4'h6
`define DTCC_MD_ONESHOT 4'h7
`define DTCC_MD_SQUARE 4'h8
`define DTCC_MD_PWM 4'h9

// Clock source selects
`define DTCC_CS_BUS 2'h0
`define DTCC_CS_OSC 2'h1
`define DTCC_CS_PRESC 2'h2
`define DTCC_CS_COUNT 2'h3

`endif

// ==== core/dtcc_edge_sync.v ====
// Purpose: Two-stage synchroniser with registered edge pulses
// Assumes: async_i comes from outside the clk_sys_i domain
// Notes: Pulses are one cycle long, two to three cycles after the pin edge
`timescale 1ns/1ps
`default_nettype none
module dtcc_edge_sync (
  input wire clk_sys_i,
  input wire rst_i,
  input wire async_i,
  output wire level_o,
  output wire rise_o,
  output wire fall_o
);
  reg meta_reg;
  reg sync_reg;
  reg last_reg;
  reg rise_reg;
  reg fall_reg;

  // Only sync_reg reads meta_reg
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
      rise_reg <= 1'b0;
      fall_reg <= 1'b0;
    end else begin
      meta_reg <= async_i;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
      rise_reg <= sync_reg & ~last_reg;
      fall_reg <= ~sync_reg & last_reg;
    end
  end

  assign level_o = last_reg;
  assign rise_o = rise_reg;
  assign fall_o = fall_reg;
endmodule // dtcc_edge_sync
`default_nettype wire

// ==== core/dtcc_config_control.v ====
// Purpose: Configuration, flags and run gating of a splittable 32-bit timer
// Assumes: APB slave, zero wait states; counter core lives outside
// Notes: Counter core reports wraps, captures and matches as pulses
// How it works
// - Four-bit high mode: reload, up/down, captures, oneshot, square, PWM
// - Three-bit low mode in split use, reload through oneshot only
// - Split clear gives one 32-bit counter, set gives two 16-bit ones
// - High or 32-bit wrap from all ones sets high overflow flag
// - Capture, down reload or PWM match sets high extra flag, except in reload or square mode
// - Low wrap from all ones sets low overflow flag in any setting
// - Low extra flag like high one, only when split, not reload
// - High run bit plus master gate permits high or 32-bit counting
// - Low run bit counts only when split and master gate allows
// - Master run bit works only in the master instance, driven out
// - Each half's master gate enable demands the shared run line
// - PWM: state clears on overflow, sets on compare match
// - Pulse and duty capture modes set state on leading capture
// - Other modes toggle state on each wrap from all ones
// - PWM and square wave drive the event pin from high state
// - High interrupt from enabled high overflow or extra flag
// - Low interrupt from enabled low overflow or extra flag
// - Debug halt bit set freezes counting while core is halted
// - High clock select: bus, oscillator, prescaler, count input falls
// - Low clock select applies only when split, else high select
// - Set and clear aliases sit four and eight bytes above base
// - Prescaler counts reload to all ones, divides by 256 minus reload
`timescale 1ns/1ps
`default_nettype none
`include "dtcc_consts.vh"
module dtcc_config_control #(
  parameter ADDR_W = 12,
  parameter IS_MASTER = 1
) (
  input wire clk_sys_i,
  input wire rst_i,
  // APB slave
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [ADDR_W-1:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire [3:0] pstrb_i,
  output wire [31:0] prdata_o,
  output wire pready_o,
  output wire pslverr_o,
  // Shared master run line
  input wire master_run_line_i,
  output wire master_run_line_o,
  // Processor debug state, same clock
  input wire debug_halted_i,
  // Pins from outside the clock domain
  input wire ext_osc_i,
  input wire count_input_signal_i,
  input wire external_event_pin_i,
  output wire external_event_pin_o,
  output wire external_event_pin_oe_n_o,
  // Events reported by the counter core
  input wire high_wrap_i,
  input wire high_capture_i,
  input wire high_down_reload_i,
  input wire high_match_i,
  input wire high_run_set_i,
  input wire high_run_clr_i,
  input wire low_wrap_i,
  input wire low_capture_i,
  input wire low_down_reload_i,
  input wire low_match_i,
  input wire low_run_set_i,
  input wire low_run_clr_i,
  // Controls towards the counter core
  output wire high_count_en_o,
  output wire low_count_en_o,
  output wire split_enable_o,
  output wire [3:0] high_mode_field_o,
  output wire [2:0] low_mode_field_o,
  output wire event_rise_o,
  output wire event_fall_o,
  output wire event_level_o,
  // Interrupt requests
  output wire high_irq_o,
  output wire low_irq_o
);

  // Decoders shared by both halves, plus the bus byte-lane mask
  function is_pulse_cap;
    input [3:0] mode;
    begin
      is_pulse_cap = (mode == `DTCC_MD_CAP_LOW) ||
                     (mode == `DTCC_MD_CAP_HIGH) ||
                     (mode == `DTCC_MD_CAP_DUTY);
    end
  endfunction

  function extra_allowed;
    input [3:0] mode;
    begin
      extra_allowed = (mode != `DTCC_MD_RELOAD) &&
                      (mode != `DTCC_MD_SQUARE);
    end
  endfunction

  function extra_event;
    input [3:0] mode;
    input capture;
    input down_reload;
    input match;
    begin
      extra_event = extra_allowed(mode) &&
                    (capture || down_reload ||
                     (match && (mode == `DTCC_MD_PWM)));
    end
  endfunction

  function tick_sel;
    input [1:0] sel;
    input osc_tick;
    input presc_tick;
    input count_tick;
    begin
      case (sel)
        `DTCC_CS_BUS: tick_sel = 1'b1;
        `DTCC_CS_OSC: tick_sel = osc_tick;
        `DTCC_CS_PRESC: tick_sel = presc_tick;
        `DTCC_CS_COUNT: tick_sel = count_tick;
        default: tick_sel = 1'b0;
      endcase
    end
  endfunction

  function [31:0] lane_mask;
    input [3:0] strb;
    begin
      lane_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    end
  endfunction

  reg [31:0] cfg_reg;
  reg [31:0] cfg_next;
  reg [7:0] presc_rl_reg;
  reg [7:0] presc_rl_next;
  reg [7:0] presc_cnt_reg;
  reg presc_tick_reg;
  reg [31:0] rdata_reg;
  reg [31:0] rdata_next;
  reg pin_out_reg;
  reg pin_oe_n_reg;
  wire [31:0] wmask;
  wire [31:0] wbits;
  wire access;
  wire wr_all;
  wire wr_set;
  wire wr_clr;
  wire wr_presc;
  wire addr_ok;
  wire [2:0] sync_in;
  wire [2:0] sync_level;
  wire [2:0] sync_rise;
  wire [2:0] sync_fall;
  wire osc_tick;
  wire count_tick;
  wire [3:0] high_mode;
  wire [3:0] low_mode;
  wire split;
  wire master_line;
  wire freeze;
  wire high_gate;
  wire low_gate;
  wire [1:0] low_sel;
  wire hext_set;
  wire lext_set;

  // Bus decode; the slave never inserts wait states
  assign access = psel_i & penable_i;
  assign addr_ok = (paddr_i == `DTCC_OFS_CFG_ALL) ||
                   (paddr_i == `DTCC_OFS_CFG_SET) ||
                   (paddr_i == `DTCC_OFS_CFG_CLR) ||
                   (paddr_i == `DTCC_OFS_PRESC);
  assign pready_o = 1'b1;
  assign pslverr_o = access & ~addr_ok;
  assign wr_all = access & pwrite_i & (paddr_i == `DTCC_OFS_CFG_ALL);
  assign wr_set = access & pwrite_i & (paddr_i == `DTCC_OFS_CFG_SET);
  assign wr_clr = access & pwrite_i & (paddr_i == `DTCC_OFS_CFG_CLR);
  assign wr_presc = access & pwrite_i & (paddr_i == `DTCC_OFS_PRESC);
  // Reserved bits never store, so they always read as zero
  assign wmask = lane_mask(pstrb_i) & `DTCC_CFG_WMASK;
  assign wbits = pwdata_i & wmask;

  // Pin inputs: oscillator, count input, event pin
  assign sync_in = {external_event_pin_i, count_input_signal_i, ext_osc_i};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
      dtcc_edge_sync u_sync (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .async_i(sync_in[gi]),
        .level_o(sync_level[gi]),
        .rise_o(sync_rise[gi]),
        .fall_o(sync_fall[gi])
      );
    end
  endgenerate

  assign osc_tick = sync_rise[0];
  assign count_tick = sync_fall[1];
  assign event_rise_o = sync_rise[2];
  assign event_fall_o = sync_fall[2];
  assign event_level_o = sync_level[2];

  // Mode and split decode
  assign split = cfg_reg[`DTCC_B_SPLIT];
  assign high_mode = cfg_reg[`DTCC_B_HMD_HI:`DTCC_B_HMD_LO];
  // Low field tops out at oneshot, so square and PWM stay high-only
  assign low_mode = {1'b0, cfg_reg[`DTCC_B_LMD_HI:`DTCC_B_LMD_LO]};
  assign split_enable_o = split;
  assign high_mode_field_o = high_mode;
  assign low_mode_field_o = cfg_reg[`DTCC_B_LMD_HI:`DTCC_B_LMD_LO];

  // Only the master instance drives the shared line
  assign master_run_line_o = (IS_MASTER != 0) ?
                             cfg_reg[`DTCC_B_MRUN] : 1'b0;
  assign master_line = (IS_MASTER != 0) ?
                       cfg_reg[`DTCC_B_MRUN] : master_run_line_i;

  // Run gating
  assign freeze = cfg_reg[`DTCC_B_DBG] & debug_halted_i;
  assign high_gate = cfg_reg[`DTCC_B_HIGH_RUN_BIT] &
                     (~cfg_reg[`DTCC_B_HMSTR] | master_line);
  assign low_gate = split ?
                    (cfg_reg[`DTCC_B_LOW_RUN_BIT] &
                     (~cfg_reg[`DTCC_B_LMSTR] | master_line)) :
                    high_gate;
  assign low_sel = split ? cfg_reg[`DTCC_B_LOW_CLOCK_SELECT_HI:`DTCC_B_LOW_CLOCK_SELECT_LO] :
                   cfg_reg[`DTCC_B_HCLK_HI:`DTCC_B_HCLK_LO];
  assign high_count_en_o = high_gate & ~freeze &
                           tick_sel(cfg_reg[`DTCC_B_HCLK_HI:`DTCC_B_HCLK_LO],
                                    osc_tick, presc_tick_reg,
                                    count_tick);
  assign low_count_en_o = low_gate & ~freeze &
                          tick_sel(low_sel, osc_tick, presc_tick_reg,
                                   count_tick);

  // Interrupt requests
  assign high_irq_o = (cfg_reg[`DTCC_B_HOVF] & cfg_reg[`DTCC_B_HOVF_EN]) |
                      (cfg_reg[`DTCC_B_HEXT] &
                       cfg_reg[`DTCC_B_HEXT_EN]);
  assign low_irq_o = (cfg_reg[`DTCC_B_LOVF] & cfg_reg[`DTCC_B_LOVF_EN]) |
                     (cfg_reg[`DTCC_B_LEXT] &
                      cfg_reg[`DTCC_B_LEXT_EN]);

  // Extra flag causes
  assign hext_set = extra_event(high_mode, high_capture_i,
                                high_down_reload_i, high_match_i);
  assign lext_set = split &
                    extra_event(low_mode, low_capture_i,
                                low_down_reload_i, low_match_i);

  // Configuration next value: software first, then hardware on top
  always @* begin
    cfg_next = cfg_reg;
    if (wr_all) begin
      cfg_next = (cfg_reg & ~wmask) | wbits;
    end else if (wr_set) begin
      cfg_next = cfg_reg | wbits;
    end else if (wr_clr) begin
      cfg_next = cfg_reg & ~wbits;
    end
    if (IS_MASTER == 0) begin
      cfg_next[`DTCC_B_MRUN] = 1'b0;
    end
    // Flag set beats a clear landing in the same cycle
    if (high_wrap_i) begin
      cfg_next[`DTCC_B_HOVF] = 1'b1;
    end
    if (hext_set) begin
      cfg_next[`DTCC_B_HEXT] = 1'b1;
    end
    if (low_wrap_i) begin
      cfg_next[`DTCC_B_LOVF] = 1'b1;
    end
    if (lext_set) begin
      cfg_next[`DTCC_B_LEXT] = 1'b1;
    end
    // Run bits moved by oneshot and capture sequences in the core
    if (high_run_clr_i) begin
      cfg_next[`DTCC_B_HIGH_RUN_BIT] = 1'b0;
    end else if (high_run_set_i) begin
      cfg_next[`DTCC_B_HIGH_RUN_BIT] = 1'b1;
    end
    if (low_run_clr_i) begin
      cfg_next[`DTCC_B_LOW_RUN_BIT] = 1'b0;
    end else if (low_run_set_i) begin
      cfg_next[`DTCC_B_LOW_RUN_BIT] = 1'b1;
    end
    // High state bit
    if (high_mode == `DTCC_MD_PWM) begin
      if (high_wrap_i) begin
        cfg_next[`DTCC_B_HIGH_STATE_BIT] = 1'b0;
      end else if (high_match_i) begin
        cfg_next[`DTCC_B_HIGH_STATE_BIT] = 1'b1;
      end
    end else if (is_pulse_cap(high_mode)) begin
      if (high_capture_i) begin
        cfg_next[`DTCC_B_HIGH_STATE_BIT] = 1'b1;
      end
    end else if (high_wrap_i) begin
      cfg_next[`DTCC_B_HIGH_STATE_BIT] = ~cfg_reg[`DTCC_B_HIGH_STATE_BIT];
    end
    // Low state bit; low mode cannot be PWM
    if (split && is_pulse_cap(low_mode)) begin
      if (low_capture_i) begin
        cfg_next[`DTCC_B_LOW_STATE_BIT] = 1'b1;
      end
    end else if (low_wrap_i) begin
      cfg_next[`DTCC_B_LOW_STATE_BIT] = ~cfg_reg[`DTCC_B_LOW_STATE_BIT];
    end
  end

  // Prescaler reload, byte lane 0 only
  always @* begin
    presc_rl_next = presc_rl_reg;
    if (wr_presc && pstrb_i[0]) begin
      presc_rl_next = pwdata_i[`DTCC_B_PRL_HI:`DTCC_B_PRL_LO];
    end
  end

  // Read data is sampled in the setup cycle
  always @* begin
    rdata_next = 32'h0000_0000;
    case (paddr_i)
      `DTCC_OFS_CFG_ALL: rdata_next = cfg_reg;
      `DTCC_OFS_CFG_SET: rdata_next = cfg_reg;
      `DTCC_OFS_CFG_CLR: rdata_next = cfg_reg;
      `DTCC_OFS_PRESC: begin
        rdata_next[`DTCC_B_PRL_HI:`DTCC_B_PRL_LO] = presc_rl_reg;
        rdata_next[`DTCC_B_PCT_HI:`DTCC_B_PCT_LO] = presc_cnt_reg;
      end
      default: rdata_next = 32'h0000_0000;
    endcase
  end

  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      cfg_reg <= `DTCC_CFG_RESET;
      presc_rl_reg <= `DTCC_PRESC_RESET;
      rdata_reg <= 32'h0000_0000;
    end else begin
      cfg_reg <= cfg_next;
      presc_rl_reg <= presc_rl_next;
      if (psel_i && !penable_i && !pwrite_i) begin
        rdata_reg <= rdata_next;
      end
    end
  end

  // Free-running divider: one tick each 256 minus reload cycles
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      presc_cnt_reg <= `DTCC_PRESC_RESET;
      presc_tick_reg <= 1'b0;
    end else if (presc_cnt_reg == `DTCC_PRESC_TOP) begin
      presc_cnt_reg <= presc_rl_reg;
      presc_tick_reg <= 1'b1;
    end else begin
      presc_cnt_reg <= presc_cnt_reg + 8'h01;
      presc_tick_reg <= 1'b0;
    end
  end

  // Event pin driver; registered so the pin never glitches on mode writes
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      pin_out_reg <= 1'b0;
      pin_oe_n_reg <= 1'b1;
    end else if ((high_mode == `DTCC_MD_PWM) ||
                 (high_mode == `DTCC_MD_SQUARE)) begin
      pin_out_reg <= cfg_reg[`DTCC_B_HIGH_STATE_BIT];
      pin_oe_n_reg <= 1'b0;
    end else begin
      pin_out_reg <= 1'b0;
      pin_oe_n_reg <= 1'b1;
    end
  end

  assign prdata_o = rdata_reg;
  assign external_event_pin_o = pin_out_reg;
  assign external_event_pin_oe_n_o = pin_oe_n_reg;
endmodule // dtcc_config_control
`default_nettype wire

// ==== test/dtcc_partner.sv ====
// Purpose: Far side of the timer: event pin, clock pins, master run line
// Assumes: Driven from the bus clock; go_i starts pin activity
// Notes: Clock pins, and the event pin while undriven, stand still while go_i is low
`timescale 1ns/1ps
`default_nettype none
module dtcc_partner (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic go_i,
  input wire logic mrun_i,
  input wire logic drv_i,
  input wire logic oe_n_i,
  output logic line_o,
  output logic osc_o,
  output logic count_o,
  output logic pin_o,
  output logic [7:0] falls_o
);
  logic [1:0] div;
  logic ph;
  // Master instance bit fanned out as the common line
  assign line_o = mrun_i;
  // Half period of four bus cycles keeps the source well below half rate
  assign osc_o = ph;
  assign count_o = ph;
  // Pin shows the block's value while it drives, else our own level
  assign pin_o = oe_n_i ? ph : drv_i;
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      div <= 2'h0;
      ph <= 1'b0;
      falls_o <= 8'h00;
    end else if (go_i) begin
      div <= div + 2'h1;
      if (div == 2'h3) begin
        ph <= !ph;
        if (ph) falls_o <= falls_o + 8'h01;
      end
    end
  end
endmodule // dtcc_partner
`default_nettype wire

// ==== test/dtcc_config_control_asserts.sv ====
// Purpose: Port-level checks of the timer configuration block
// Assumes: Single bus clock, synchronous active-high reset
// Notes: Flags are internal; they are judged by the bench through reads
`timescale 1ns/1ps
`default_nettype none
module dtcc_config_control_asserts #(
  parameter ADDR_W = 12,
  parameter IS_MASTER = 1
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic master_run_line_o,
  input wire logic split_enable_o,
  input wire logic [3:0] high_mode_field_o,
  input wire logic high_count_en_o,
  input wire logic low_count_en_o,
  input wire logic external_event_pin_i,
  input wire logic external_event_pin_oe_n_o,
  input wire logic event_rise_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  logic acc, wr_all, mapped;
  assign acc = psel_i && penable_i;
  assign wr_all = acc && pwrite_i && paddr_i == 'h0;
  assign mapped = paddr_i inside {'h0, 'h4, 'h8, 'h10};
  property p_ready; acc |-> pready_o; endproperty
  a_ready: assert property (p_ready)
    else $error("access without ready");
  property p_err; acc && !mapped |-> pslverr_o; endproperty
  a_err: assert property (p_err)
    else $error("unmapped access not refused");
  property p_ok; acc && mapped |-> !pslverr_o; endproperty
  a_ok: assert property (p_ok)
    else $error("mapped access refused");
  property p_mrun;
    wr_all && pstrb_i[2] |=>
      master_run_line_o == ((IS_MASTER != 0) && $past(pwdata_i[19]));
  endproperty
  a_mrun: assert property (p_mrun)
    else $error("master run line differs from written bit");
  property p_split;
    wr_all && pstrb_i[0] |=> split_enable_o == $past(pwdata_i[5]);
  endproperty
  a_split: assert property (p_split)
    else $error("split enable not written");
  property p_hmode;
    wr_all && pstrb_i[3] |=> high_mode_field_o == $past(pwdata_i[27:24]);
  endproperty
  a_hmode: assert property (p_hmode)
    else $error("high mode not written");
  property p_set;
    acc && pwrite_i && paddr_i == 'h4 && pstrb_i[0] && pwdata_i[5]
      |=> split_enable_o;
  endproperty
  a_set: assert property (p_set)
    else $error("set alias did not set bit");
  property p_lowf;
    !split_enable_o |-> low_count_en_o == high_count_en_o;
  endproperty
  a_lowf: assert property (p_lowf)
    else $error("low half not following high gating");
  // Mode must hold two cycles, so either register timing of oe passes
  property p_pin;
    high_mode_field_o inside {4'h8, 4'h9} ##1 $stable(high_mode_field_o)
      |-> !external_event_pin_oe_n_o;
  endproperty
  a_pin: assert property (p_pin)
    else $error("pin not driven in waveform mode");
  property p_rise;
    $rose(external_event_pin_i) |-> ##[1:4] event_rise_o ##1 !event_rise_o;
  endproperty
  a_rise: assert property (p_rise)
    else $error("pin edge not turned into one pulse");
  c_err: cover property (acc && !mapped);
  c_pwm: cover property (!external_event_pin_oe_n_o);
  c_low: cover property (low_count_en_o && split_enable_o);
endmodule // dtcc_config_control_asserts
bind dtcc_config_control dtcc_config_control_asserts #(
  .ADDR_W(ADDR_W), .IS_MASTER(IS_MASTER)) u_chk (.clk_sys_i, .rst_i,
  .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i,
  .pready_o, .pslverr_o, .master_run_line_o, .split_enable_o,
  .high_mode_field_o, .high_count_en_o, .low_count_en_o,
  .external_event_pin_i, .external_event_pin_oe_n_o, .event_rise_o);
`default_nettype wire

// ==== test/dual_timer_config_control_test.sv ====
// Purpose: Self-checking bench of the timer configuration block
// Assumes: Zero-wait APB slave; counter core events driven by the bench
// Notes: Expected words follow the field layout of the control register
`timescale 1ns/1ps
`default_nettype none
module dual_timer_config_control_test;
  logic clk_sys_i, rst_i, psel, pen, pwr, dbg, go, err, ol;
  logic [11:0] paddr, hw;
  logic [31:0] pwdata, rdat;
  logic [3:0] pstrb;
  wire logic [31:0] prdata;
  wire logic prdy, perr, mro, pdrv, oe_n, pin, osc, cnt, mrl, hce, lce;
  wire logic hirq, lirq;
  wire logic [7:0] falls;
  int miscompares, check_count, c, i, r;
  dtcc_config_control dut (.clk_sys_i, .rst_i, .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
    .pstrb_i(pstrb), .prdata_o(prdata), .pready_o(prdy), .pslverr_o(perr),
    .master_run_line_i(mrl), .master_run_line_o(mro),
    .debug_halted_i(dbg), .ext_osc_i(osc), .count_input_signal_i(cnt),
    .external_event_pin_i(pin), .external_event_pin_o(pdrv),
    .external_event_pin_oe_n_o(oe_n), .high_wrap_i(hw[11]),
    .high_capture_i(hw[10]), .high_down_reload_i(hw[9]),
    .high_match_i(hw[8]), .high_run_set_i(hw[7]), .high_run_clr_i(hw[6]),
    .low_wrap_i(hw[5]), .low_capture_i(hw[4]), .low_down_reload_i(hw[3]),
    .low_match_i(hw[2]), .low_run_set_i(hw[1]), .low_run_clr_i(hw[0]),
    .high_count_en_o(hce), .low_count_en_o(lce), .split_enable_o(),
    .high_mode_field_o(), .low_mode_field_o(), .event_rise_o(),
    .event_fall_o(), .event_level_o(), .high_irq_o(hirq),
    .low_irq_o(lirq));
  dtcc_partner u_far (.clk_sys_i, .rst_i, .go_i(go), .mrun_i(mro),
    .drv_i(pdrv), .oe_n_i(oe_n), .line_o(mrl), .osc_o(osc),
    .count_o(cnt), .pin_o(pin), .falls_o(falls));
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  task end_sim;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Holds the request until ready is seen; one idle cycle after each
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    input logic [3:0] s);
    int n;
    psel <= 1'b1; pwr <= w; paddr <= a; pwdata <= d; pstrb <= s;
    @(posedge clk_sys_i);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (prdy !== 1'b1 && n < 20);
    if (n >= 20) begin
      miscompares++;
      end_sim;
    end
    rdat = prdata; err = perr;
    psel <= 1'b0; pen <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hf);
  endtask
  task rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, 4'hf);
    chk("register", e, rdat);
  endtask
  task pulse(input logic [11:0] m);
    hw <= m;
    @(posedge clk_sys_i);
    hw <= 12'h000;
    @(posedge clk_sys_i);
  endtask
  task t_regs;
    rdc(12'h000, 32'h0); rdc(12'h004, 32'h0);
    // Live prescaler count moves every cycle, so only the reload is judged
    apb(1'b0, 12'h010, 32'h0, 4'hf);
    chk("reload", 32'h0, rdat[15:0]);
    wr(12'h000, 32'hffffffff); rdc(12'h000, 32'hfffbf7f3);
    wr(12'h008, 32'hffffffff); rdc(12'h000, 32'h0);
    apb(1'b1, 12'h000, 32'hffffffff, 4'h1); rdc(12'h000, 32'hf3);
    wr(12'h000, 32'h0); wr(12'h004, 32'h00800020);
    rdc(12'h008, 32'h00800020);
    wr(12'h008, 32'h20); rdc(12'h000, 32'h00800000);
    apb(1'b0, 12'h00c, 32'h0, 4'hf);
    chk("refused", 1, err); chk("unmapped", 0, rdat);
    wr(12'h00c, 32'hffffffff); rdc(12'h000, 32'h00800000);
  endtask
  task t_flags;
    wr(12'h000, 32'h00800080);
    pulse(12'h800); rdc(12'h000, 32'h90800080);
    chk("high irq", 1, hirq);
    pulse(12'h800); rdc(12'h000, 32'h80800080);
    pulse(12'h020); rdc(12'h000, 32'h80809080);
    chk("low irq", 1, lirq);
    wr(12'h008, 32'h80008000); rdc(12'h000, 32'h00801080);
    chk("irqs clear", 0, {hirq, lirq});
    wr(12'h000, 32'h00400040); pulse(12'h410);
    rdc(12'h000, 32'h00400040);
    wr(12'h000, 32'h02400260); pulse(12'h410);
    rdc(12'h000, 32'h42404260);
    chk("extra irqs", 3, {hirq, lirq});
    wr(12'h000, 32'h01000000); pulse(12'h200);
    rdc(12'h000, 32'h41000000);
    wr(12'h000, 32'h08000000); pulse(12'h400);
    rdc(12'h000, 32'h08000000);
    wr(12'h000, 32'h20); pulse(12'h010); rdc(12'h000, 32'h20);
  endtask
  task t_state;
    wr(12'h000, 32'h09000000); pulse(12'h100);
    rdc(12'h000, 32'h59000000);
    chk("pin high", 2'b10, {pdrv, oe_n});
    pulse(12'h900); rdc(12'h000, 32'hc9000000);
    chk("pin low", 2'b00, {pdrv, oe_n});
    wr(12'h000, 32'h04000000); pulse(12'h400); pulse(12'h800);
    rdc(12'h000, 32'hd4000000);
    wr(12'h000, 32'h00000520); pulse(12'h010);
    rdc(12'h000, 32'h00005520);
    chk("pin released", 1, oe_n);
  endtask
  task t_run;
    wr(12'h000, 32'h20000000); chk("high run", 2'b11, {hce, lce});
    wr(12'h004, 32'h00100000); chk("gated", 0, hce);
    wr(12'h004, 32'h00080000); chk("master on", 1, hce);
    dbg <= 1'b1; wr(12'h004, 32'h00200000);
    chk("debug halt", 0, hce);
    dbg <= 1'b0; wr(12'h000, 32'h00002030);
    chk("low gated", 2'b00, {hce, lce});
    wr(12'h004, 32'h00080000); chk("low run", 2'b01, {hce, lce});
    wr(12'h000, 32'h20000000); pulse(12'h040);
    rdc(12'h000, 32'h0);
  endtask
  task t_clk;
    wr(12'h010, 32'hfc); apb(1'b0, 12'h010, 32'h0, 4'hf);
    chk("reload", 32'hfc, rdat[15:0]);
    wr(12'h000, 32'h20020000);
    // The old reload period must run out before the new one shows
    repeat (256) @(posedge clk_sys_i);
    c = 0;
    for (i = 0; i < 100; i++) begin
      @(posedge clk_sys_i);
      if (hce === 1'b1) c++;
    end
    chk("prescaled ticks", 25, c);
    wr(12'h000, 32'h20030000);
    c = 0;
    go <= 1'b1;
    for (i = 0; i < 110; i++) begin
      @(posedge clk_sys_i);
      if (i == 96) go <= 1'b0;
      if (hce === 1'b1) c++;
    end
    chk("count falls", falls, c);
    wr(12'h000, 32'h20010000);
    c = 0; r = 0; ol = osc;
    go <= 1'b1;
    for (i = 0; i < 110; i++) begin
      @(posedge clk_sys_i);
      if (i == 96) go <= 1'b0;
      if (osc === 1'b1 && ol === 1'b0) r++;
      ol = osc;
      if (hce === 1'b1) c++;
    end
    chk("osc rises", r, c);
  endtask
  initial begin
    rst_i = 1'b1; psel = 1'b0; pen = 1'b0; pwr = 1'b0; dbg = 1'b0;
    go = 1'b0; paddr = 12'h000; pwdata = 32'h0; pstrb = 4'hf;
    hw = 12'h000; miscompares = 0; check_count = 0;
    repeat (3) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(posedge clk_sys_i);
    t_regs;
    t_flags;
    t_state;
    t_run;
    t_clk;
    end_sim;
  end
endmodule // dual_timer_config_control_test
`default_nettype wire
